//--- rtl/csc_top.sv
// Clamp, sync monitor and channel configuration register bank with APB slave
// What this block does
// (RULE_01) Coast-clamp bit 4 picks internal Hsync clamp (0) or external clamp (1).
// (RULE_02) Bits 3,2,1 pick red, green, blue clamp target: ground or midscale.
// (RULE_03) Software keeps coast-clamp bit 0 at zero.
// (RULE_04) Internal clamp starts placement-register clocks after Hsync trailing edge.
// (RULE_05) Internal clamp lasts duration-register clocks, default 32.
// (RULE_06) External clamp polarity is automatic unless the override bit is set.
// (RULE_07) Polarity bit counts only under override: 0 active low, 1 high.
// (RULE_08) Bit 5 enables auto-offset; offsets then mean target clamp code.
// (RULE_09) Update field: every 3, 48, 192 clamps, or every 3 Vsyncs.
// (RULE_10) Software writes clamp-offset low bits as 011.
// (RULE_11) Software writes all ones to the factory test byte.
// (RULE_12) Green-sync bits 7:3 set the slicer comparator threshold.
// (RULE_13) Green-sync bit 2 sets monitor output polarity: 0 low, 1 high.
// (RULE_14) Monitor select: raw green, raw line sync, regenerated, filtered sync.
// (RULE_15) Channel override 0 lets the block choose the input channel.
// (RULE_16) Channel bit applies under override or when both channels have syncs.
// (RULE_17) Power bit 5 selects low (7 MHz) or high analog bandwidth.
// (RULE_18) Power bit 4 selects manual (0) or automatic (1) power-down.
// (RULE_19) Coast-clamp bit 7 picks Vsync-derived coast or external coast pin.
// (RULE_20) Clamp counters restart each Hsync trailing edge, drive only internal clamp; edges during an active pulse are ignored.
// (RULE_21) Registers reset to defaults; writes apply next sync, pulses undisturbed; code delays only placement and duration, others apply next cycle.
`timescale 1ns/10ps
module csc_top
  import csc_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic [31:0]      prdata_out,
  output logic             pslverr_out,
  input  wire logic        line_sync_input_zero_in,
  input  wire logic        line_sync_input_one_in,
  input  wire logic        green_sync_input_zero_in,
  input  wire logic        green_sync_input_one_in,
  input  wire logic        vsync_in,
  input  wire logic        ext_clamp_in,
  input  wire logic        ext_coast_in,
  input  wire logic        regen_sync_in,
  input  wire logic        filtered_sync_in,
  output logic             clamp_out,
  output logic [2:0]       clamp_midscale_out,
  output logic             coast_out,
  output logic             sync_monitor_output_out,
  output logic [4:0]       slicer_threshold_out,
  output logic             bandwidth_high_out,
  output logic             auto_power_down_out,
  output logic             channel_sel_out,
  output logic             auto_offset_en_out,
  output logic             offset_update_out
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [CSC_NPIN-1:0] s1;
    logic [CSC_NPIN-1:0] s2;
    logic [CSC_NPIN-1:0] s3;
    logic [CSC_NPIN-1:0] pin;
    logic [CSC_NPIN-1:0] pin_prev;
    logic [7:0]          cc;
    logic [7:0]          place;
    logic [7:0]          dur;
    logic [7:0]          co;
    logic [7:0]          test;
    logic [7:0]          gs;
    logic [7:0]          pw;
    csc_clamp_st_t       st;
    logic [7:0]          cnt;
    logic [7:0]          dur_l;
    logic [7:0]          upd_cnt;
    logic [11:0]         act_cnt0;
    logic [11:0]         act_cnt1;
    logic                act0;
    logic                act1;
    logic [11:0]         pol_cnt;
    logic                pol_auto;
    logic                clamp_prev;
    logic                clamp;
    logic [2:0]          target;
    logic                coast;
    logic                mon;
    logic                chan;
    logic                upd;
    logic                pready;
    logic [31:0]         prdata;
    logic                pslverr;
  } csc_state_t;

  csc_state_t q;
  csc_state_t d;

  // Mapped register check, shared by read and write decode
  function automatic logic csc_known(input logic [5:0] idx);
    csc_known = (idx >= CSC_IDX_COAST_CLAMP && idx <= CSC_IDX_POWER_CHAN) ||
                (idx == CSC_IDX_STATUS);
  endfunction

  // Update period in events for the auto-offset loop
  function automatic logic [7:0] csc_upd_period(input logic [1:0] mode);
    case (mode)
      2'h0:    csc_upd_period = CSC_UPD_EVERY_3;
      2'h1:    csc_upd_period = CSC_UPD_EVERY_48;
      2'h2:    csc_upd_period = CSC_UPD_EVERY_192;
      default: csc_upd_period = CSC_UPD_EVERY_3;
    endcase
  endfunction

  logic [CSC_NPIN-1:0] pins_raw;
  assign pins_raw = {ext_coast_in, ext_clamp_in, vsync_in, green_sync_input_one_in,
                     green_sync_input_zero_in, line_sync_input_one_in,
                     line_sync_input_zero_in};

  logic       apb_acc;
  logic [5:0] apb_idx;
  logic       apb_ok;
  logic       line_cur;
  logic       line_prev;
  logic       trail;
  logic       ext_pol;
  logic       ext_act;
  logic       int_pulse;
  logic       upd_evt;
  logic       mon_src;
  logic       coast_pol;

  assign apb_acc = psel_in & penable_in;
  assign apb_idx = paddr_in[7:2];
  assign apb_ok  = (paddr_in[1:0] == 2'h0) && csc_known(apb_idx);

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    d = q;
    // Three-stage synchroniser; a change counts once stages two and three agree
    d.s1 = pins_raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.pin_prev = q.pin;
    for (int i = 0; i < CSC_NPIN; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.pin[i] = q.s3[i];
      end
    end

    // Line sync activity per channel, restarted by each leading edge
    if (q.pin[CSC_PIN_LINE0] & ~q.pin_prev[CSC_PIN_LINE0]) begin
      d.act_cnt0 = '0;
      d.act0     = 1'b1;
    end else if (q.act_cnt0 == CSC_ACT_CYC) begin
      d.act0 = 1'b0;
    end else begin
      d.act_cnt0 = q.act_cnt0 + 12'h001;
    end
    if (q.pin[CSC_PIN_LINE1] & ~q.pin_prev[CSC_PIN_LINE1]) begin
      d.act_cnt1 = '0;
      d.act1     = 1'b1;
    end else if (q.act_cnt1 == CSC_ACT_CYC) begin
      d.act1 = 1'b0;
    end else begin
      d.act_cnt1 = q.act_cnt1 + 12'h001;
    end

    // RULE_15 RULE_16 channel choice
    if (q.pw[CSC_PW_CHAN_OVR] || (q.act0 && q.act1)) begin
      d.chan = q.pw[CSC_PW_CHAN_SEL];
    end else if (q.act0) begin
      d.chan = 1'b0;
    end else if (q.act1) begin
      d.chan = 1'b1;
    end

    // Line sync treated active high; its trailing edge is the falling edge
    line_cur  = q.chan ? q.pin[CSC_PIN_LINE1] : q.pin[CSC_PIN_LINE0];
    line_prev = q.chan ? q.pin_prev[CSC_PIN_LINE1] : q.pin_prev[CSC_PIN_LINE0];
    trail     = line_prev & ~line_cur;

    // RULE_04 RULE_05 RULE_20 RULE_21 placement and duration counting
    case (q.st)
      CSC_CS_IDLE: begin
        if (trail) begin
          d.st    = CSC_CS_PLACE;
          d.cnt   = q.place;
          d.dur_l = q.dur;
        end
      end
      CSC_CS_PLACE: begin
        // Duration is latched at the edge so a write mid-line waits a line
        if (trail) begin
          d.cnt   = q.place;
          d.dur_l = q.dur;
        end else if (q.cnt != 8'h00) begin
          d.cnt = q.cnt - 8'h01;
        end else if (q.dur_l != 8'h00) begin
          d.st  = CSC_CS_ACTIVE;
          d.cnt = q.dur_l - 8'h01;
        end else begin
          d.st = CSC_CS_IDLE;
        end
      end
      CSC_CS_ACTIVE: begin
        // A pulse in progress runs to its end; a new edge here is not counted
        if (q.cnt != 8'h00) begin
          d.cnt = q.cnt - 8'h01;
        end else begin
          d.st = CSC_CS_IDLE;
        end
      end
      default: begin
        d.st  = CSC_CS_IDLE;
        d.cnt = 8'h00;
      end
    endcase
    int_pulse = (q.st == CSC_CS_ACTIVE);

    // RULE_06 RULE_07 external clamp polarity, automatic from the idle level
    if (q.pin[CSC_PIN_CLAMP] != q.pin_prev[CSC_PIN_CLAMP]) begin
      d.pol_cnt = '0;
    end else if (q.pol_cnt == CSC_POL_CYC) begin
      d.pol_auto = ~q.pin[CSC_PIN_CLAMP];
    end else begin
      d.pol_cnt = q.pol_cnt + 12'h001;
    end
    ext_pol = q.co[CSC_CO_POL_OVR] ? q.co[CSC_CO_POL] : q.pol_auto;
    ext_act = ext_pol ? q.pin[CSC_PIN_CLAMP] : ~q.pin[CSC_PIN_CLAMP];

    // RULE_01 clamp source select
    d.clamp      = q.cc[CSC_CC_CLAMP_SRC] ? ext_act : int_pulse;
    d.clamp_prev = q.clamp;
    // RULE_02 per-channel clamp target
    d.target     = q.cc[CSC_CC_TARGET_HI:CSC_CC_TARGET_LO];

    // RULE_19 coast source; external coast polarity honours its override
    coast_pol = q.cc[CSC_CC_COAST_OVR] ? q.cc[CSC_CC_COAST_POL] : 1'b1;
    d.coast   = q.cc[CSC_CC_COAST_SRC]
              ? (coast_pol ? q.pin[CSC_PIN_COAST] : ~q.pin[CSC_PIN_COAST])
              : q.pin[CSC_PIN_VSYNC];

    // RULE_08 RULE_09 auto-offset update scheduling
    d.upd = 1'b0;
    if (q.co[CSC_CO_UPD_HI:CSC_CO_UPD_LO] == CSC_UPD_VSYNC) begin
      upd_evt = q.pin[CSC_PIN_VSYNC] & ~q.pin_prev[CSC_PIN_VSYNC];
    end else begin
      upd_evt = q.clamp & ~q.clamp_prev;
    end
    if (!q.co[CSC_CO_AUTO_EN]) begin
      d.upd_cnt = 8'h00;
    end else if (upd_evt) begin
      if (q.upd_cnt + 8'h01 >= csc_upd_period(q.co[CSC_CO_UPD_HI:CSC_CO_UPD_LO])) begin
        d.upd_cnt = 8'h00;
        d.upd     = 1'b1;
      end else begin
        d.upd_cnt = q.upd_cnt + 8'h01;
      end
    end

    // RULE_14 RULE_13 sync monitor source and polarity
    case (q.gs[CSC_GS_MON_SEL_HI:CSC_GS_MON_SEL_LO])
      CSC_MON_RAW_GREEN: mon_src = q.chan ? q.pin[CSC_PIN_GRN1] : q.pin[CSC_PIN_GRN0];
      CSC_MON_RAW_LINE:  mon_src = line_cur;
      CSC_MON_REGEN:     mon_src = regen_sync_in;
      CSC_MON_FILTERED:  mon_src = filtered_sync_in;
      default:           mon_src = 1'b0;
    endcase
    d.mon = q.gs[CSC_GS_MON_POL] ? mon_src : ~mon_src;

    // APB: ready one cycle into the access phase, write on the ready edge
    d.pready  = apb_acc & ~q.pready;
    d.pslverr = apb_acc & ~q.pready & ~apb_ok;
    if (apb_acc & ~q.pready) begin
      d.prdata = 32'h0000_0000;
      if (!pwrite_in && apb_ok) begin
        case (apb_idx)
          CSC_IDX_COAST_CLAMP: d.prdata[7:0] = q.cc;
          CSC_IDX_PLACEMENT:   d.prdata[7:0] = q.place;
          CSC_IDX_DURATION:    d.prdata[7:0] = q.dur;
          CSC_IDX_CLAMP_OFS:   d.prdata[7:0] = q.co;
          CSC_IDX_TEST_BYTE:   d.prdata[7:0] = q.test;
          CSC_IDX_GREEN_SYNC:  d.prdata[7:0] = q.gs;
          CSC_IDX_POWER_CHAN:  d.prdata[7:0] = q.pw;
          CSC_IDX_STATUS:      d.prdata[7:0] = {3'h0, q.pol_auto, int_pulse,
                                                 q.act1, q.act0, q.chan};
          default:             d.prdata[7:0] = 8'h00;
        endcase
      end
    end
    if (apb_acc && q.pready && pwrite_in && apb_ok) begin
      case (apb_idx)
        CSC_IDX_COAST_CLAMP: d.cc    = pwdata_in[7:0];
        CSC_IDX_PLACEMENT:   d.place = pwdata_in[7:0];
        CSC_IDX_DURATION:    d.dur   = pwdata_in[7:0];
        CSC_IDX_CLAMP_OFS:   d.co    = pwdata_in[7:0];
        CSC_IDX_TEST_BYTE:   d.test  = pwdata_in[7:0];
        CSC_IDX_GREEN_SYNC:  d.gs    = pwdata_in[7:0];
        CSC_IDX_POWER_CHAN:  d.pw    = pwdata_in[7:0];
        default:             d.cc    = q.cc;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // RULE_21 defaults on reset
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      q       <= '0;
      q.st    <= CSC_CS_IDLE;
      q.cc    <= CSC_RST_COAST_CLAMP;
      q.place <= CSC_RST_PLACEMENT;
      q.dur   <= CSC_RST_DURATION;
      q.co    <= CSC_RST_CLAMP_OFS;
      q.test  <= CSC_RST_TEST_BYTE;
      q.gs    <= CSC_RST_GREEN_SYNC;
      q.pw    <= CSC_RST_POWER_CHAN;
      q.mon   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign pready_out              = q.pready;
  assign prdata_out              = q.prdata;
  assign pslverr_out             = q.pslverr;
  assign clamp_out               = q.clamp;
  assign clamp_midscale_out      = q.target;
  assign coast_out               = q.coast;
  assign sync_monitor_output_out = q.mon;
  // RULE_12 slicer threshold field
  assign slicer_threshold_out    = q.gs[CSC_GS_THR_HI:CSC_GS_THR_LO];
  // RULE_17 RULE_18 bandwidth and power-down mode
  assign bandwidth_high_out      = q.pw[CSC_PW_BANDWIDTH];
  assign auto_power_down_out     = q.pw[CSC_PW_AUTO_PD];
  assign channel_sel_out         = q.chan;
  assign auto_offset_en_out      = q.co[CSC_CO_AUTO_EN];
  assign offset_update_out       = q.upd;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking csc_cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  clamp_source_a: assert property ( // RULE_01
    q.cc[CSC_CC_CLAMP_SRC] == 1'b0 |=> clamp_out == $past(q.st == CSC_CS_ACTIVE))
    else $error("internal clamp output does not follow pulse state");
  clamp_target_a: assert property ( // RULE_02
    ##1 clamp_midscale_out == $past(q.cc[3:1]))
    else $error("clamp target does not follow control bits");
  clamp_place_a: assert property ( // RULE_04
    (q.st == CSC_CS_PLACE && q.cnt == 8'h00 && q.dur_l != 8'h00 && !trail)
      |=> q.st == CSC_CS_ACTIVE && q.cnt == $past(q.dur_l) - 8'h01)
    else $error("pulse did not start when placement count ran out");
  clamp_dur_a: assert property ( // RULE_05
    $rose(q.st == CSC_CS_ACTIVE) && q.cnt == 8'h01
      |-> (q.st == CSC_CS_ACTIVE) [*2] ##1 q.st == CSC_CS_IDLE)
    else $error("clamp pulse length wrong");
  ext_polarity_a: assert property ( // RULE_07
    q.cc[CSC_CC_CLAMP_SRC] && q.co[CSC_CO_POL_OVR]
      |=> clamp_out == ($past(q.co[CSC_CO_POL]) ~^ $past(q.pin[CSC_PIN_CLAMP])))
    else $error("external clamp polarity override not honoured");
  offset_update_a: assert property ( // RULE_08
    offset_update_out |-> auto_offset_en_out || $past(q.co[CSC_CO_AUTO_EN]))
    else $error("offset update while auto-offset disabled");
  monitor_pol_a: assert property ( // RULE_13
    q.gs[1:0] == CSC_MON_REGEN |=> sync_monitor_output_out ==
      ($past(regen_sync_in) ~^ $past(q.gs[CSC_GS_MON_POL])))
    else $error("sync monitor source or polarity wrong");
  channel_ovr_a: assert property ( // RULE_15
    q.pw[CSC_PW_CHAN_OVR] |=> channel_sel_out == $past(q.pw[CSC_PW_CHAN_SEL]))
    else $error("channel override not honoured");
  coast_src_a: assert property ( // RULE_19
    !q.cc[CSC_CC_COAST_SRC] |=> coast_out == $past(q.pin[CSC_PIN_VSYNC]))
    else $error("internal coast does not follow vsync");
  apb_ready_a: assert property (
    psel_in && penable_in && !pready_out |=> pready_out)
    else $error("apb ready not given one cycle into access");

endmodule

//--- rtl/csc_pkg.sv
// Constants and types for the clamp, sync and channel configuration block
package csc_pkg;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [5:0] CSC_IDX_COAST_CLAMP = 6'h18;
  localparam logic [5:0] CSC_IDX_PLACEMENT   = 6'h19;
  localparam logic [5:0] CSC_IDX_DURATION    = 6'h1a;
  localparam logic [5:0] CSC_IDX_CLAMP_OFS   = 6'h1b;
  localparam logic [5:0] CSC_IDX_TEST_BYTE   = 6'h1c;
  localparam logic [5:0] CSC_IDX_GREEN_SYNC  = 6'h1d;
  localparam logic [5:0] CSC_IDX_POWER_CHAN  = 6'h1e;
  localparam logic [5:0] CSC_IDX_STATUS      = 6'h30;

  // ---------------------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CSC_RST_COAST_CLAMP = 8'h20;
  localparam logic [7:0] CSC_RST_PLACEMENT   = 8'h08;
  localparam logic [7:0] CSC_RST_DURATION    = 8'h20;
  localparam logic [7:0] CSC_RST_CLAMP_OFS   = 8'h5b;
  localparam logic [7:0] CSC_RST_TEST_BYTE   = 8'hff;
  localparam logic [7:0] CSC_RST_GREEN_SYNC  = 8'h78;
  localparam logic [7:0] CSC_RST_POWER_CHAN  = 8'h30;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CSC_CC_COAST_SRC   = 7;
  localparam int CSC_CC_COAST_OVR   = 6;
  localparam int CSC_CC_COAST_POL   = 5;
  localparam int CSC_CC_CLAMP_SRC   = 4;
  localparam int CSC_CC_TARGET_HI   = 3;
  localparam int CSC_CC_TARGET_LO   = 1;
  localparam int CSC_CO_POL_OVR     = 7;
  localparam int CSC_CO_POL         = 6;
  localparam int CSC_CO_AUTO_EN     = 5;
  localparam int CSC_CO_UPD_HI      = 4;
  localparam int CSC_CO_UPD_LO      = 3;
  localparam int CSC_GS_THR_HI      = 7;
  localparam int CSC_GS_THR_LO      = 3;
  localparam int CSC_GS_MON_POL     = 2;
  localparam int CSC_GS_MON_SEL_HI  = 1;
  localparam int CSC_GS_MON_SEL_LO  = 0;
  localparam int CSC_PW_CHAN_OVR    = 7;
  localparam int CSC_PW_CHAN_SEL    = 6;
  localparam int CSC_PW_BANDWIDTH   = 5;
  localparam int CSC_PW_AUTO_PD     = 4;

  // ---------------------------------------------------------------------------
  // Auto-offset update periods and sync monitor sources
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CSC_UPD_EVERY_3   = 8'h03;
  localparam logic [7:0] CSC_UPD_EVERY_48  = 8'h30;
  localparam logic [7:0] CSC_UPD_EVERY_192 = 8'hc0;
  localparam logic [1:0] CSC_UPD_VSYNC     = 2'h3;
  localparam logic [1:0] CSC_MON_RAW_GREEN = 2'h0;
  localparam logic [1:0] CSC_MON_RAW_LINE  = 2'h1;
  localparam logic [1:0] CSC_MON_REGEN     = 2'h2;
  localparam logic [1:0] CSC_MON_FILTERED  = 2'h3;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int         CSC_CLK_MHZ    = 25;
  localparam int         CSC_ACT_US     = 100;  // Line sync activity timeout
  localparam int         CSC_POL_IDLE_US = 20;  // Steady level taken as idle
  localparam logic [11:0] CSC_ACT_CYC   = 12'(CSC_ACT_US * CSC_CLK_MHZ);
  localparam logic [11:0] CSC_POL_CYC   = 12'(CSC_POL_IDLE_US * CSC_CLK_MHZ);

  // Pin bit positions in the synchronised input vector
  localparam int CSC_NPIN      = 7;
  localparam int CSC_PIN_LINE0 = 0;
  localparam int CSC_PIN_LINE1 = 1;
  localparam int CSC_PIN_GRN0  = 2;
  localparam int CSC_PIN_GRN1  = 3;
  localparam int CSC_PIN_VSYNC = 4;
  localparam int CSC_PIN_CLAMP = 5;
  localparam int CSC_PIN_COAST = 6;

  typedef enum logic [2:0] {
    CSC_CS_IDLE   = 3'b001,
    CSC_CS_PLACE  = 3'b010,
    CSC_CS_ACTIVE = 3'b100
  } csc_clamp_st_t;

endpackage

//--- sim/csc_src_model.sv
// Video source model: periodic line, sliced green and frame syncs
`timescale 1ns/10ps
module csc_src_model #(
  parameter int LINE = 100,
  parameter int VLN  = 4
) (
  input  wire logic clk_in,
  input  wire logic run_in,
  output logic      line_out,
  output logic      green_out,
  output logic      vsync_out
);
  int c = 0;
  int l = 0;

  // Idle levels are defined so that a stopped source never reads as unknown
  initial begin
    line_out = 1'b0;
    green_out = 1'b1;
    vsync_out = 1'b0;
  end

  // Line sync high 16 clocks a line; green sync is its active-low copy
  always @(posedge clk_in) begin
    c <= (c == LINE - 1) ? 0 : c + 1;
    if (c == LINE - 1) l <= (l == VLN - 1) ? 0 : l + 1;
    line_out <= run_in && c < 16;
    green_out <= !(run_in && c < 16);
    vsync_out <= run_in && l == 0 && c < 50;
  end
endmodule

//--- sim/test_clamp_sync_channel_config.sv
// Self-checking bench for the clamp, sync and channel register bank
`timescale 1ns/10ps
module test_clamp_sync_channel_config
  import csc_pkg::*;
;
  localparam logic [5:0] RIDX[7] = '{6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d, 6'h1e};
  localparam logic [7:0] RDEF[7] = '{8'h20, 8'h08, 8'h20, 8'h5b, 8'hff, 8'h78, 8'h30};
  localparam int         UPD[4]  = '{3, 48, 192, 3};
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic run = 1'b0, eclamp = 1'b0, ecoast = 1'b0, regen = 1'b0, filt = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic pready, pslverr, clamp, coast, mon, bw, apd, chs, aoe, upd, line, grn, vs;
  logic lp, cp, vp;
  logic [31:0] prdata;
  logic [2:0] mid;
  logic [4:0] thr;
  logic [33:0] q[$];
  logic [33:0] e;
  int fail_count = 0;
  int comparisons = 0;

  initial forever #20 clk = ~clk;

  csc_top csc_top_inst (.core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd),
    .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
    .line_sync_input_zero_in(line), .line_sync_input_one_in(line),
    .green_sync_input_zero_in(grn), .green_sync_input_one_in(grn), .vsync_in(vs),
    .ext_clamp_in(eclamp), .ext_coast_in(ecoast), .regen_sync_in(regen),
    .filtered_sync_in(filt), .clamp_out(clamp), .clamp_midscale_out(mid),
    .coast_out(coast), .sync_monitor_output_out(mon), .slicer_threshold_out(thr),
    .bandwidth_high_out(bw), .auto_power_down_out(apd), .channel_sel_out(chs),
    .auto_offset_en_out(aoe), .offset_update_out(upd));

  csc_src_model csc_src_model_inst (.clk_in(clk), .run_in(run), .line_out(line),
    .green_out(grn), .vsync_out(vs));

  // -------------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------------
  task automatic complete_run();
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One transfer; held until pready is sampled, one idle cycle after it
  task automatic apb(input logic w, input logic [5:0] idx, input logic [1:0] lo,
                     input logic [7:0] d, input logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    padr <= {idx, lo};
    pwd <= {24'h0, d};
    q.push_back({!w, err, err ? 32'h0 : {24'h0, d}});
    @(posedge clk);
    pen <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      complete_run();
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  // Clocks from a line sync trailing edge to clamp rise, then clamp width
  task automatic meas(output int dly, output int wid);
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (!(lp && !line) && n < 300);
    dly = 0;
    do begin @(posedge clk); dly++; end while (clamp !== 1'b1 && dly < 300);
    wid = 0;
    do begin @(posedge clk); wid++; end while (clamp === 1'b1 && wid < 300);
    if (n >= 300 || dly >= 300 || wid >= 300) begin
      fail_count++;
      complete_run();
    end
  endtask

  // Edge history for event counting
  always @(posedge clk) begin
    lp <= line;
    cp <= clamp;
    vp <= vs;
  end

  // Each answer is compared with the oldest queued expectation
  always @(posedge clk) begin
    if (pready === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      check({31'h0, pslverr}, {31'h0, e[32]});
      if (e[33]) check(prdata, e[31:0]);
    end
  end

  // -------------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------------
  initial begin
    int i, k, n, p, d, w, d1;
    logic [7:0] v;
    void'($urandom(47859));
    tick(5);
    rst_n <= 1'b1;
    tick(2);
    for (i = 0; i < 7; i++) apb(0, RIDX[i], 2'h0, RDEF[i], 0);
    check(32'(thr), 32'h0f);
    // factory test byte written all ones
    apb(1, CSC_IDX_TEST_BYTE, 2'h0, 8'hff, 0);
    apb(0, 6'h3f, 2'h0, 8'h00, 1);
    apb(1, CSC_IDX_PLACEMENT, 2'h1, 8'h55, 1);
    apb(0, CSC_IDX_PLACEMENT, 2'h0, 8'h08, 0);
    // bit zero of the clamp control is kept clear
    for (i = 0; i < 4; i++) begin
      v = $urandom;
      apb(1, CSC_IDX_COAST_CLAMP, 2'h0, {4'h0, v[3:1], 1'b0}, 0);
      apb(1, CSC_IDX_POWER_CHAN, 2'h0, {1'b1, v[6:4], 4'h0}, 0);
      apb(0, CSC_IDX_POWER_CHAN, 2'h0, {1'b1, v[6:4], 4'h0}, 0);
      check(32'(mid), 32'(v[3:1]));
      check(32'(chs), 32'(v[6]));
      check(32'(bw), 32'(v[5]));
      check(32'(apd), 32'(v[4]));
    end
    // Monitor source and polarity with the source stopped
    for (i = 0; i < 8; i++) begin
      v = $urandom;
      regen <= v[0];
      filt <= v[1];
      apb(1, CSC_IDX_GREEN_SYNC, 2'h0, {v[7:3], 3'(i)}, 0);
      tick(3);
      n = i[1:0] == 0 ? 1 : i[1:0] == 1 ? 0 : i[1:0] == 2 ? v[0] : v[1];
      check(32'(mon), 32'(i[2] ? n[0] : !n[0]));
      check(32'(thr), 32'(v[7:3]));
    end
    // clamp and offset low bits written as 011
    for (i = 0; i < 4; i++) begin
      v = $urandom;
      eclamp <= v[0];
      ecoast <= v[1];
      apb(1, CSC_IDX_CLAMP_OFS, 2'h0, {1'b1, i[0], 6'h1b}, 0);
      apb(1, CSC_IDX_COAST_CLAMP, 2'h0, {i[1], 3'b111, 4'h0}, 0);
      tick(6);
      check(32'(clamp), 32'(i[0] ? v[0] : !v[0]));
      check(32'(coast), 32'(i[1] & v[1]));
    end
    run <= 1'b1;
    apb(1, CSC_IDX_COAST_CLAMP, 2'h0, 8'h00, 0);
    apb(1, CSC_IDX_POWER_CHAN, 2'h0, 8'h70, 0);
    tick(300);
    check(32'(chs), 32'h1);
    p = 2 + $urandom % 20;
    d = 1 + $urandom % 40;
    for (k = 0; k < 2; k++) begin
      apb(1, CSC_IDX_PLACEMENT, 2'h0, 8'(p + 5 * k), 0);
      apb(1, CSC_IDX_DURATION, 2'h0, 8'(k ? d : 2), 0);
      meas(w, n);
      meas(w, n);
      if (k == 0) d1 = w;
      else check(32'(w - d1), 32'h5);
      check(32'(n), 32'(k ? d : 2));
    end
    // Offset loop period for every update mode
    for (i = 0; i < 4; i++) begin
      apb(1, CSC_IDX_CLAMP_OFS, 2'h0, {3'b011, i[1:0], 3'b011}, 0);
      check(32'(aoe), 32'h1);
      k = 0;
      do begin @(posedge clk); k++; end while (upd !== 1'b1 && k < 40000);
      n = 0;
      do begin
        @(posedge clk);
        k++;
        n += (i == 3) ? int'(vs && !vp) : int'(clamp && !cp);
      end while (upd !== 1'b1 && k < 80000);
      if (k >= 80000) begin
        fail_count++;
        complete_run();
      end
      check(32'(n), 32'(UPD[i]));
    end
    complete_run();
  end
endmodule
